// ---- src/ocd_pkg.sv ----
// Shared constants, register layouts and state types of the oscillator clock control.
package ocd_pkg;

    // Register bus geometry and map.
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  MISC_OFS      = 8'h00;
    localparam logic [7:0]  STATUS_OFS    = 8'h04;
    localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

    // Main divider and stabilization counter presets.
    localparam logic [6:0]  PRESC_PRESET  = 7'h78;
    localparam logic [5:0]  STAB_PRESET   = 6'h00;
    localparam logic [5:0]  STAB_FULL     = 6'h3f;
    localparam logic [6:0]  PRESC_ONE     = 7'h01;
    localparam logic [5:0]  STAB_ONE      = 6'h01;

    // Divider tap masks: a tap fires when all its low bits are ones.
    localparam logic [6:0]  TAP_DIV2      = 7'h01;
    localparam logic [6:0]  TAP_DIV4      = 7'h03;
    localparam logic [6:0]  TAP_DIV64     = 7'h3f;
    localparam logic [6:0]  TAP_DIV128    = 7'h7f;

    // Sub-oscillator timebase counter.
    localparam logic [13:0] TB_PRESET     = 14'h0078;
    localparam logic [13:0] TB_ONE        = 14'h0001;
    localparam int          SUB_READY_CNT = 8072;

    // Synchronised pin indices.
    localparam int PIN_MAIN = 0;
    localparam int PIN_SUB  = 1;
    localparam int PIN_EXT_IRQ_ONE = 2;
    localparam int PIN_EXT_IRQ_TWO = 3;
    localparam int PIN_KEY  = 4;
    localparam int PIN_N    = 5;

    typedef enum logic [1:0] {
        SEL_DIV2  = 2'b00,
        SEL_DIV4  = 2'b01,
        SEL_DIV64 = 2'b10,
        SEL_SUB   = 2'b11
    } ocd_sel_e;

    typedef enum logic [1:0] {
        PW_RUN     = 2'b00,
        PW_WAIT    = 2'b01,
        PW_STOP    = 2'b10,
        PW_RECOVER = 2'b11
    } ocd_pw_e;

    typedef struct packed {
        logic       main_osc_ready_flag;
        logic       sub_osc_ready_flag;
        logic [2:0] reserved;
        logic       main_osc_enable;
        logic       sysclk_select_hi;
        logic       sysclk_select_lo;
    } ocd_misc_s;

    typedef struct packed {
        logic [1:0] reserved;
        logic       reset_hold;
        logic       recovering;
        logic       stopped;
        logic       waiting;
        logic       main_running;
        logic       sub_clk_phase;
    } ocd_status_s;

    localparam ocd_misc_s MISC_RESET = '{
        main_osc_ready_flag: 1'b0,
        sub_osc_ready_flag:  1'b0,
        reserved:            3'b000,
        main_osc_enable:     1'b1,
        sysclk_select_hi:    1'b1,
        sysclk_select_lo:    1'b0
    };

endpackage

// ---- src/ocd_clock_ctrl.sv ----
// Oscillator prescaler, stabilization counter, clock select and low-power control.
//
// What this block does
// - Seven-bit main prescaler with div 2/4/64/128 taps.
// - Six-bit counter overflow sets ready, releases reset.
// - Power-on or enable clear presets both counters.
// - Two-bit select picks main or sub tick.
// - Reset selects main oscillator divided by 64.
// - Sub runs always; main stops by stop/enable.
// - Stop on main clock clears stabilization counter.
// - Main-clock stop exit waits for counter overflow.
// - External reset restores select and enable defaults.
// - Sub-clock stop exit resumes now, main restarts.
// - Enable clear stops main; reenable restarts it.
// - Enable low stop exit keeps main stopped.
// - Stop halts clocks, clears ready, inits counter.
// - Stop exits on reset, irqs, key, serial, timebase.
// - Main-clock stop resumes CPU after overflow only.
// - Wait gates CPU clock only; any interrupt exits.
// - Recovery waits follow reset kind and clock.
// - Main ready read-only, cleared by power-on, enable.
// - Sub ready set after 8072 timebase counts.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module ocd_clock_ctrl
    import ocd_pkg::*;
#(
    parameter int SUB_READY_COUNT = SUB_READY_CNT
) (
    // Clock and resets
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              por_i,
    // Oscillator pins
    input  wire logic              main_oscillator_i,
    input  wire logic              sub_oscillator_i,
    output logic                   main_osc_run_o,
    // Wake pins
    input  wire logic              ext_irq_one_i,
    input  wire logic              ext_irq_two_i,
    input  wire logic              key_wakeup_input_i,
    // CPU and peripheral requests
    input  wire logic              stop_req_i,
    input  wire logic              wait_req_i,
    input  wire logic              any_irq_i,
    input  wire logic              simple_serial_port_wake_i,
    input  wire logic              timebase_irq_i,
    // Clock ticks and reset out
    output logic                   cpu_clk_tick_o,
    output logic                   periph_clk_tick_o,
    output logic                   timebase_tick_o,
    output logic                   internal_reset_o,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic [DATA_W-1:0]      prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o
);

    localparam logic [13:0] TB_READY = TB_PRESET + 14'(SUB_READY_COUNT);

    function automatic logic tap_hit(input logic [6:0] cnt, input logic [6:0] mask);
        tap_hit = ((cnt & mask) == mask);
    endfunction

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        addr_is = (a == ADDR_W'(ofs));
    endfunction

    logic [PIN_N-1:0] pin_meta;
    logic [PIN_N-1:0] pin_sync;
    logic [PIN_N-1:0] pin_last;
    logic             main_edge;
    logic             sub_edge;
    logic             wake_pin;

    ocd_misc_s        misc;
    logic             main_osc_enable;
    logic             sysclk_select_hi;
    logic             sysclk_select_lo;
    logic             main_osc_ready_flag;
    logic             sub_osc_ready_flag;
    ocd_pw_e          pw_state;
    logic [6:0]       presc;
    logic [5:0]       stab;
    logic [13:0]      tb_cnt;
    logic             sub_half;
    logic             reset_hold;
    logic             main_run;
    logic             main_tick;
    logic             overflow;
    logic             sysclk_tick;
    logic             stop_wake;
    logic             apb_setup;
    logic             apb_access;
    logic             mapped;
    logic             misc_wr;
    logic [DATA_W-1:0] next_rdata;
    ocd_sel_e         sel;

    // Only the second and third stages are looked at; the first may be metastable.
    // Power-on only: clearing them on external reset would fake an edge on a high pin.
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_last <= '0;
        end else begin
            pin_meta <= {key_wakeup_input_i, ext_irq_two_i, ext_irq_one_i,
                         sub_oscillator_i, main_oscillator_i};
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign main_edge = pin_sync[PIN_MAIN] && !pin_last[PIN_MAIN];
    assign sub_edge  = pin_sync[PIN_SUB] && !pin_last[PIN_SUB];
    assign wake_pin  = pin_sync[PIN_EXT_IRQ_ONE] || pin_sync[PIN_EXT_IRQ_TWO] || pin_sync[PIN_KEY];

    assign sel       = ocd_sel_e'({misc.sysclk_select_hi, misc.sysclk_select_lo});
    assign main_run  = misc.main_osc_enable && (pw_state != PW_STOP);
    assign main_tick = main_edge && main_run;
    assign overflow  = main_tick && tap_hit(presc, TAP_DIV128) && (stab == STAB_FULL);
    assign stop_wake = wake_pin || simple_serial_port_wake_i || timebase_irq_i;

    // Main prescaler: preset on power-on or while enable is low, left alone by stop.
    always_ff @(posedge sys_clk_i) begin
        if (por_i || !misc.main_osc_enable) begin
            presc <= PRESC_PRESET;
        end else if (main_tick) begin
            presc <= presc + PRESC_ONE;
        end
    end

    // Stabilization counter, clocked by the divide-by-128 tap.
    always_ff @(posedge sys_clk_i) begin
        if (por_i || !misc.main_osc_enable) begin
            stab <= STAB_PRESET;
        end else if (pw_state != PW_STOP && stop_req_i && pw_state == PW_RUN) begin
            stab <= STAB_PRESET;
        end else if (main_tick && tap_hit(presc, TAP_DIV128)) begin
            stab <= stab + STAB_ONE;
        end
    end

    // The sub-oscillator never stops, so its counter has no stop gating.
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            tb_cnt   <= TB_PRESET;
            sub_half <= 1'b0;
        end else if (sub_edge) begin
            tb_cnt   <= tb_cnt + TB_ONE;
            sub_half <= !sub_half;
        end
    end

    // Power-state sequencer.
    always_ff @(posedge sys_clk_i) begin
        if (por_i || rst_i) begin
            pw_state <= PW_RUN;
        end else begin
            unique case (pw_state)
                PW_RUN: begin
                    if (stop_req_i) begin
                        pw_state <= PW_STOP;
                    end else if (wait_req_i) begin
                        pw_state <= PW_WAIT;
                    end
                end
                PW_WAIT: begin
                    if (any_irq_i) begin
                        pw_state <= PW_RUN;
                    end
                end
                PW_STOP: begin
                    if (stop_wake) begin
                        if (sel == SEL_SUB) begin
                            pw_state <= PW_RUN;
                        end else begin
                            pw_state <= PW_RECOVER;
                        end
                    end
                end
                PW_RECOVER: begin
                    if (overflow) begin
                        pw_state <= PW_RUN;
                    end
                end
            endcase
        end
    end

    // Reset hold: power-on always waits, external reset only with main stopped.
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            reset_hold <= 1'b1;
        end else if (rst_i && !main_run) begin
            reset_hold <= 1'b1;
        end else if (overflow) begin
            reset_hold <= 1'b0;
        end
    end

    assign internal_reset_o = por_i || rst_i || reset_hold;

    // Control fields follow external reset; ready flags only power-on.
    always_ff @(posedge sys_clk_i) begin
        if (por_i || rst_i) begin
            main_osc_enable  <= MISC_RESET.main_osc_enable;
            sysclk_select_hi <= MISC_RESET.sysclk_select_hi;
            sysclk_select_lo <= MISC_RESET.sysclk_select_lo;
        end else if (misc_wr) begin
            main_osc_enable  <= pwdata_i[2];
            sysclk_select_hi <= pwdata_i[1];
            sysclk_select_lo <= pwdata_i[0];
        end
    end

    // The view is rebuilt from separate flops so each field has one driver.
    assign misc = '{
        main_osc_ready_flag: main_osc_ready_flag,
        sub_osc_ready_flag:  sub_osc_ready_flag,
        reserved:            MISC_RESET.reserved,
        main_osc_enable:     main_osc_enable,
        sysclk_select_hi:    sysclk_select_hi,
        sysclk_select_lo:    sysclk_select_lo
    };

    // Overflow wins over a clear in the same cycle.
    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            main_osc_ready_flag <= 1'b0;
        end else if (overflow) begin
            main_osc_ready_flag <= 1'b1;
        end else if (!misc.main_osc_enable || pw_state == PW_STOP) begin
            main_osc_ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (por_i) begin
            sub_osc_ready_flag <= 1'b0;
        end else if (sub_edge && (tb_cnt + TB_ONE) == TB_READY) begin
            sub_osc_ready_flag <= 1'b1;
        end
    end

    // Selected system tick; a wrong select with a dead source gives no ticks.
    always_comb begin
        unique case (sel)
            SEL_DIV2:  sysclk_tick = main_tick && tap_hit(presc, TAP_DIV2);
            SEL_DIV4:  sysclk_tick = main_tick && tap_hit(presc, TAP_DIV4);
            SEL_DIV64: sysclk_tick = main_tick && tap_hit(presc, TAP_DIV64);
            SEL_SUB:   sysclk_tick = sub_edge && sub_half;
        endcase
    end

    assign cpu_clk_tick_o    = sysclk_tick && (pw_state == PW_RUN) && !reset_hold;
    assign periph_clk_tick_o = sysclk_tick && (pw_state == PW_RUN || pw_state == PW_WAIT);
    assign timebase_tick_o   = main_tick && tap_hit(presc, TAP_DIV128);
    assign main_osc_run_o    = main_run;

    // APB: zero wait states, read data captured in the setup cycle.
    assign apb_setup  = psel_i && !penable_i;
    assign apb_access = psel_i && penable_i;
    assign mapped     = addr_is(paddr_i, MISC_OFS) || addr_is(paddr_i, STATUS_OFS);
    assign misc_wr    = apb_access && pwrite_i && addr_is(paddr_i, MISC_OFS) && pstrb_i[0];
    assign pready_o   = apb_access;
    assign pslverr_o  = apb_access && !mapped;

    always_comb begin
        next_rdata = RDATA_ZERO;
        if (addr_is(paddr_i, MISC_OFS)) begin
            next_rdata = DATA_W'(misc);
        end else if (addr_is(paddr_i, STATUS_OFS)) begin
            next_rdata = DATA_W'(ocd_status_s'{
                reserved:      2'b00,
                reset_hold:    reset_hold,
                recovering:    (pw_state == PW_RECOVER),
                stopped:       (pw_state == PW_STOP),
                waiting:       (pw_state == PW_WAIT),
                main_running:  main_run,
                sub_clk_phase: sub_half
            });
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || por_i) begin
            prdata_o <= RDATA_ZERO;
        end else if (apb_setup && !pwrite_i) begin
            prdata_o <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ---- bench/ocd_clock_ctrl_monitor.sv ----
// Port checker for the oscillator clock control.
`timescale 1ns/1ps
`default_nettype none
module ocd_clock_ctrl_monitor
    import ocd_pkg::*;
(
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire logic              por_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              main_osc_run_o,
    input wire logic              cpu_clk_tick_o,
    input wire logic              periph_clk_tick_o,
    input wire logic              timebase_tick_o,
    input wire logic              internal_reset_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_acc;
        psel_i && penable_i;
    endsequence
    sequence s_bad;
        s_acc ##0 (paddr_i != MISC_OFS && paddr_i != STATUS_OFS);
    endsequence
    AST_ACC_READY: assert property (s_acc |-> pready_o)
        else $error("access phase without ready");
    AST_BAD_ADDR: assert property (s_bad |-> pslverr_o)
        else $error("unmapped access not flagged");
    AST_POR_RESET: assert property (por_i |-> internal_reset_o)
        else $error("power-on detect without internal reset");
    AST_POR_HOLD: assert property ($fell(por_i) |-> internal_reset_o [*8])
        else $error("internal reset released too early");
    AST_HOLD_CPU: assert property (internal_reset_o |-> !cpu_clk_tick_o)
        else $error("cpu clock during reset hold");
    AST_WAIT_GATE: assert property (cpu_clk_tick_o |-> periph_clk_tick_o)
        else $error("cpu clock without peripheral clock");
    AST_MAIN_GATE: assert property (!main_osc_run_o |-> !timebase_tick_o)
        else $error("timebase ticks with main oscillator stopped");
    AST_TB_SPACE: assert property (timebase_tick_o |=> !timebase_tick_o [*8])
        else $error("timebase ticks too close");
endmodule
bind ocd_clock_ctrl ocd_clock_ctrl_monitor ocd_clock_ctrl_monitor_i (.sys_clk_i, .rst_i,
    .por_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .main_osc_run_o,
    .cpu_clk_tick_o, .periph_clk_tick_o, .timebase_tick_o, .internal_reset_o);
`default_nettype wire

// ---- bench/ocd_osc_model.sv ----
// Behavioural main and sub oscillators driving the clock control pins.
`timescale 1ns/1ps
`default_nettype none
module ocd_osc_model #(
    parameter int SUB_HALF = 5
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      main_o,
    output logic      sub_o
);
    logic mp = 1'b0;
    int   sc = 0;
    initial main_o = 1'b0;
    initial sub_o = 1'b0;
    // A halted crystal rests low, so no stale edge appears on restart.
    always @(posedge clk_i) begin
        mp <= ~mp;
        if (!run_i) main_o <= 1'b0;
        else if (mp) main_o <= ~main_o;
        sc <= (sc == SUB_HALF - 1) ? 0 : sc + 1;
        if (sc == SUB_HALF - 1) sub_o <= ~sub_o;
    end
endmodule
`default_nettype wire

// ---- bench/osc_clock_distribution_tb.sv ----
// Self-checking bench for the oscillator clock control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected t=%0t got=%0h exp=%0h", $time, g, e); end end
module osc_clock_distribution_tb
    import ocd_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1, stp = 1'b0, wt = 1'b0, irq = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr, errq, prdy, mrun, ct, pt, tt, ir, mo, so;
    logic [4:0]  wk = 5'h0;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0000_0000, prd;
    int n_mismatch = 0, compares = 0;
    bit mrdy, srdy, men;
    bit [1:0] msel;
    int gap[4] = '{8, 16, 256, 20};
    ocd_clock_ctrl #(.SUB_READY_COUNT(8)) ocd_clock_ctrl_i (.sys_clk_i(clk), .rst_i(rst),
        .por_i(por), .main_oscillator_i(mo), .sub_oscillator_i(so), .main_osc_run_o(mrun),
        .ext_irq_one_i(wk[0]), .ext_irq_two_i(wk[1]), .key_wakeup_input_i(wk[2]),
        .simple_serial_port_wake_i(wk[3]), .timebase_irq_i(wk[4]), .stop_req_i(stp),
        .wait_req_i(wt), .any_irq_i(irq), .cpu_clk_tick_o(ct), .periph_clk_tick_o(pt),
        .timebase_tick_o(tt), .internal_reset_o(ir), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hf), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr));
    ocd_osc_model #(.SUB_HALF(5)) ocd_osc_model_i (.clk_i(clk), .run_i(mrun), .main_o(mo),
        .sub_o(so));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic summarize();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd;
        errq = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic wr_misc(input bit e, input bit [1:0] s);
        logic [31:0] r;
        // Bits 7:6 are read-only, so random values there must not stick.
        apb(1'b1, MISC_OFS, {24'h0, 2'($urandom), 3'h0, e, s}, r);
        men = e;
        msel = s;
        if (!e) mrdy = 1'b0;
    endtask
    task automatic chk_misc();
        logic [31:0] r;
        apb(1'b0, MISC_OFS, 32'h0000_0000, r);
        `CHK(r, {24'h0, mrdy, srdy, 3'h0, men, msel})
    endtask
    task automatic next_tick(output int n);
        n = 0;
        do begin @(posedge clk); n++; end while (ct !== 1'b1);
    endtask
    task automatic do_stop(input int src, input bit en);
        int p, n;
        logic [31:0] r;
        @(posedge clk) stp <= 1'b1;
        @(posedge clk) stp <= 1'b0;
        p = 0;
        repeat (20 + $urandom_range(0, 15)) begin @(posedge clk); p += pt; end
        `CHK({p != 0, mrun}, 2'b00)
        apb(1'b0, STATUS_OFS, 32'h0000_0000, r);
        `CHK(r & 32'h0000_003e, 32'h0000_0008)
        wk[src] <= 1'b1;
        next_tick(n);
        `CHK({n < 60, mrun}, {1'b1, en})
        wk[src] <= 1'b0;
    endtask
    initial begin
        int n, cc, pc;
        logic [31:0] r;
        time t0;
        n = $urandom(32'hac9c98b0);
        repeat (2) @(posedge clk);
        rst <= 1'b0; por <= 1'b0;
        n = 0;
        while (ir !== 1'b0) begin @(posedge clk); n++; end
        `CHK(n inside {[32200:32400]}, 1'b1)
        mrdy = 1; srdy = 1; men = 1; msel = SEL_DIV64;
        chk_misc();
        for (int s = 0; s < 4; s++) begin
            wr_misc(1'b1, 2'(s));
            next_tick(n);
            next_tick(n);
            `CHK(n, gap[s])
        end
        apb(1'b0, 8'h08, 32'h0000_0000, r);
        `CHK({errq, r}, 33'h1_0000_0000)
        @(posedge clk) wt <= 1'b1;
        @(posedge clk) wt <= 1'b0;
        cc = 0; pc = 0;
        repeat (60) begin @(posedge clk); cc += ct; pc += pt; end
        `CHK({cc != 0, pc != 0}, 2'b01)
        irq <= 1'b1;
        next_tick(n);
        `CHK(n < 60, 1'b1)
        irq <= 1'b0;
        do_stop(0, 1'b1);
        mrdy = 0;
        chk_misc();
        wr_misc(1'b0, SEL_SUB);
        for (int s = 0; s < 5; s++) do_stop(s, 1'b0);
        t0 = $time;
        wr_misc(1'b1, SEL_SUB);
        do apb(1'b0, MISC_OFS, 32'h0000_0000, r); while (r[7] !== 1'b1);
        n = int'(($time - t0) / 25);
        `CHK(n inside {[32200:32500]}, 1'b1)
        mrdy = 1;
        // Stop on the main clock: the wake goes to recovery and the CPU stays halted.
        wr_misc(1'b1, SEL_DIV64);
        @(posedge clk) stp <= 1'b1;
        @(posedge clk) stp <= 1'b0;
        wk[1] <= 1'b1;
        cc = 0;
        repeat (300) begin @(posedge clk); cc += ct; end
        apb(1'b0, STATUS_OFS, 32'h0000_0000, r);
        `CHK({cc != 0, r[5:1]}, 6'b0_01001)
        wk[1] <= 1'b0;
        mrdy = 0;
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        men = 1; msel = SEL_DIV64;
        repeat (2) @(posedge clk);
        `CHK(ir, 1'b0)
        chk_misc();
        summarize();
    end
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
